// ### design/status_frame_pkg.sv
package status_frame_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] START_DELIM = 8'h7E;
  localparam logic [7:0] TYPE_TX_STATUS = 8'h89;
  localparam logic [7:0] TYPE_MODEM_STATUS = 8'h8A;
  localparam logic [7:0] TYPE_TX_REQ64 = 8'h00;
  localparam logic [7:0] CSUM_BASE = 8'hFF;
  localparam logic [15:0] LEN_TX_STATUS = 16'h0003;
  localparam logic [15:0] LEN_MODEM_STATUS = 16'h0002;
  localparam logic [2:0] OFS_LEN_HI = 3'd1;
  localparam logic [2:0] OFS_LEN_LO = 3'd2;
  localparam logic [2:0] OFS_TYPE = 3'd3;
  localparam logic [2:0] OFS_FIELD4 = 3'd4;
  localparam logic [2:0] OFS_FIELD5 = 3'd5;
  localparam logic [2:0] OFS_CSUM_TX = 3'd6;
  localparam logic [2:0] OFS_CSUM_MODEM = 3'd5;

  // ----------------------------------------------------------------
  // Delivery status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] DS_SUCCESS = 8'h00;
  localparam logic [7:0] DS_MAC_ACK_FAIL = 8'h01;
  localparam logic [7:0] DS_LBT_FAIL = 8'h02;
  localparam logic [7:0] DS_PURGED = 8'h03;
  localparam logic [7:0] DS_BAD_CLUSTER = 8'h20;
  localparam logic [7:0] DS_NET_ACK_FAIL = 8'h21;
  localparam logic [7:0] DS_NO_ROUTE = 8'h25;
  localparam logic [7:0] DS_INTERNAL_ERR = 8'h31;
  localparam logic [7:0] DS_NO_BUFFERS = 8'h32;
  localparam logic [7:0] DS_NO_SESSION = 8'h34;
  localparam logic [7:0] DS_SESSION_CRYPT = 8'h35;
  localparam logic [7:0] DS_TOO_LARGE = 8'h74;
  localparam logic [7:0] DS_INDIRECT_UNREQ = 8'h75;

  // ----------------------------------------------------------------
  // Modem status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MS_POWER_UP = 8'h00;
  localparam logic [7:0] MS_WATCHDOG = 8'h01;
  localparam logic [7:0] MS_NET_WAKE = 8'h0B;
  localparam logic [7:0] MS_NET_SLEEP = 8'h0C;
  localparam logic [7:0] MS_OVER_VOLTAGE = 8'h0D;
  localparam logic [7:0] MS_BLE_DISCONNECT = 8'h33;
  localparam logic [7:0] MS_SESSION_UP = 8'h3B;
  localparam logic [7:0] MS_SESSION_END = 8'h3C;
  localparam logic [7:0] MS_SESSION_AUTH = 8'h3D;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] frame_id;
    logic broadcast;
    logic [7:0] status;
  } tx_done_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } out_byte_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } gen_state_e;

endpackage

// ### design/frame_byte_sel.sv
`timescale 1ns/1ps
module frame_byte_sel
  import status_frame_pkg::*;
(
  input wire logic [2:0] index,
  input wire logic [7:0] frame_type,
  input wire logic [7:0] field4,
  input wire logic [7:0] field5,
  input wire logic [7:0] csum_acc,
  input wire logic is_tx,
  output logic [7:0] data,
  output logic last
);

  // ----------------------------------------------------------------
  // Byte selection by offset
  // ----------------------------------------------------------------
  wire [15:0] len = is_tx ? LEN_TX_STATUS : LEN_MODEM_STATUS;
  wire [2:0] last_ofs = is_tx ? OFS_CSUM_TX : OFS_CSUM_MODEM;
  wire is_csum = (index == last_ofs);
  wire [7:0] payload_byte = (index == OFS_TYPE) ? frame_type :
                            (index == OFS_FIELD4) ? field4 : field5;
  wire [7:0] hdr_byte = (index == OFS_LEN_HI) ? len[15:8] :
                        (index == OFS_LEN_LO) ? len[7:0] : START_DELIM;

  // The checksum byte subtracts the running sum of offsets 3 onward.
  assign data = is_csum ? 8'(CSUM_BASE - csum_acc) :
                (index >= OFS_TYPE) ? payload_byte : hdr_byte;
  assign last = is_csum;

endmodule

// ### design/api_status_frame_generator.sv
`timescale 1ns/1ps
//
// Function
// - Send 0x89 status after 64-bit transmit completes.
// - Suppress status when frame identifier is zero.
// - Broadcast always reports delivery status 0x00.
// - Delimiter offset 0, length offset 1.
// - Offset 4 echoes request frame identifier.
// - Status offset 5; codes 0x00 to 0x03.
// - Codes 0x20, 0x21, 0x25, 0x31.
// - Codes 0x32, 0x34, 0x35, 0x74, 0x75.
// - Checksum is 0xFF minus sum from offset 3.
// - Send 0x8A modem frame with status code.
// - Modem codes 0x00 reset, 0x01 watchdog.
// - Codes 0x0B wake, 0x0C sleep, 0x0D voltage.
// - Session codes 0x3B, 0x3C, 0x3D; BLE 0x33.
// - Power-up sends modem status 0x00.
// - Bytes sent unescaped.
//
module api_status_frame_generator
  import status_frame_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tx_done_valid,
  input wire tx_done_s tx_done,
  output logic tx_done_ready,
  input wire logic modem_event_valid,
  input wire logic [7:0] modem_event_code,
  input wire logic watchdog_reset_cause,
  output logic modem_event_ready,
  output logic byte_valid,
  output out_byte_s byte_out,
  input wire logic byte_ready,
  output logic tx_suppressed
);

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  gen_state_e state;
  gen_state_e next_state;
  logic [2:0] index;
  logic [7:0] frame_type;
  logic [7:0] field4;
  logic [7:0] field5;
  logic [7:0] csum_acc;
  logic is_tx;
  logic boot_pending;
  logic [7:0] sel_data;
  logic sel_last;

  wire idle = (state == ST_IDLE);
  wire legacy_req = tx_done_valid && (tx_done.req_type == TYPE_TX_REQ64);
  wire tx_wanted = legacy_req && (tx_done.frame_id != 8'h00);
  // The ready pulse blocks a second drop while the host still holds its request.
  wire tx_drop = idle && !boot_pending && !tx_done_ready && legacy_req && (tx_done.frame_id == 8'h00);
  wire [7:0] tx_status = tx_done.broadcast ? DS_SUCCESS : tx_done.status;
  wire boot_go = idle && boot_pending;
  wire tx_go = idle && !boot_pending && tx_wanted;
  wire modem_go = idle && !boot_pending && !tx_wanted && !legacy_req && modem_event_valid;
  wire start = boot_go || tx_go || modem_go;
  wire [7:0] boot_code = watchdog_reset_cause ? MS_WATCHDOG : MS_POWER_UP;
  wire byte_taken = byte_valid && byte_ready;
  wire [2:0] next_index = (state == ST_SEND && byte_taken) ? 3'(index + 3'd1) : index;
  // The checksum byte follows a payload byte, so its sum must include the byte being taken now.
  wire [7:0] csum_with_cur = 8'(csum_acc + byte_out.data);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (byte_taken && byte_out.last) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Frame byte selection
  // ----------------------------------------------------------------
  frame_byte_sel u_sel (
    .index(next_index),
    .frame_type(frame_type),
    .field4(field4),
    .field5(field5),
    .csum_acc(csum_with_cur),
    .is_tx(is_tx),
    .data(sel_data),
    .last(sel_last)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      boot_pending <= 1'b1;
    end else begin
      state <= next_state;
      if (boot_go) begin
        boot_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      index <= 3'd0;
      frame_type <= 8'h00;
      field4 <= 8'h00;
      field5 <= 8'h00;
      is_tx <= 1'b0;
    end else if (start) begin
      index <= 3'd0;
      is_tx <= tx_go;
      frame_type <= tx_go ? TYPE_TX_STATUS : TYPE_MODEM_STATUS;
      field4 <= tx_go ? tx_done.frame_id : (boot_go ? boot_code : modem_event_code);
      field5 <= tx_status;
    end else begin
      index <= next_index;
    end
  end

  // Running sum covers bytes from the frame type up to the checksum.
  always_ff @(posedge sys_clk) begin
    if (reset || start) begin
      csum_acc <= 8'h00;
    end else if (byte_taken && index >= OFS_TYPE && !byte_out.last) begin
      csum_acc <= 8'(csum_acc + byte_out.data);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      byte_valid <= 1'b0;
      byte_out <= '0;
      tx_done_ready <= 1'b0;
      modem_event_ready <= 1'b0;
      tx_suppressed <= 1'b0;
    end else begin
      tx_done_ready <= tx_go || tx_drop;
      modem_event_ready <= modem_go;
      tx_suppressed <= tx_drop;
      if (start) begin
        byte_valid <= 1'b1;
        byte_out.data <= START_DELIM;
        byte_out.last <= 1'b0;
      end else if (byte_taken && byte_out.last) begin
        byte_valid <= 1'b0;
      end else if (byte_taken) begin
        byte_out.data <= sel_data;
        byte_out.last <= sel_last;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_zero_id_silent: assert property (@(posedge sys_clk) disable iff (reset)
    tx_drop |=> !byte_valid)
    else $error("zero identifier frame started");

  a_boot_frame_first: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(boot_pending) |-> byte_valid && byte_out.data == START_DELIM && frame_type == TYPE_MODEM_STATUS)
    else $error("boot frame missing");

  a_broadcast_ok: assert property (@(posedge sys_clk) disable iff (reset)
    tx_go && tx_done.broadcast |=> field5 == DS_SUCCESS)
    else $error("broadcast status not zero");

  a_tx_type: assert property (@(posedge sys_clk) disable iff (reset)
    tx_go |=> frame_type == TYPE_TX_STATUS && field4 == $past(tx_done.frame_id))
    else $error("wrong transmit status header");

  a_modem_type: assert property (@(posedge sys_clk) disable iff (reset)
    modem_go |=> frame_type == TYPE_MODEM_STATUS && field4 == $past(modem_event_code))
    else $error("wrong modem status header");

  a_len_high: assert property (@(posedge sys_clk) disable iff (reset)
    byte_taken && index == 3'd0 |=> byte_out.data == 8'h00)
    else $error("length high byte wrong");

  a_start_delim: assert property (@(posedge sys_clk) disable iff (reset)
    start |=> byte_out.data == START_DELIM ##0 byte_valid)
    else $error("delimiter missing");

  a_csum_value: assert property (@(posedge sys_clk) disable iff (reset)
    byte_valid && byte_out.last |-> byte_out.data == 8'(CSUM_BASE - csum_acc))
    else $error("checksum wrong");

  a_tx_length: assert property (@(posedge sys_clk) disable iff (reset)
    byte_valid && byte_out.last |-> index == (is_tx ? OFS_CSUM_TX : OFS_CSUM_MODEM))
    else $error("frame length wrong");

  a_len_low: assert property (@(posedge sys_clk) disable iff (reset)
    byte_taken && index == OFS_LEN_HI |=> byte_out.data == (is_tx ? LEN_TX_STATUS[7:0] : LEN_MODEM_STATUS[7:0]))
    else $error("length low byte wrong");

  a_tx_ready_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    tx_done_ready |=> !tx_done_ready)
    else $error("completion consumed twice");

  a_modem_ready_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    modem_event_ready |=> !modem_event_ready)
    else $error("modem event consumed twice");

endmodule

// ### sim/host_sink.sv
`timescale 1ns/1ps
module host_sink
  import status_frame_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic byte_valid,
  input wire out_byte_s byte_out,
  input wire logic slow,
  output logic byte_ready
);
  out_byte_s q[$];
  int pos = 0;
  int bad_csum = 0;
  logic [7:0] sum = 8'h00;
  // A slow host takes a byte only every other cycle.
  always @(posedge sys_clk) begin
    if (reset) begin
      pos = 0;
      sum = 8'h00;
    end
    if (byte_valid && byte_ready && !reset) begin
      q.push_back(byte_out);
      if (pos >= 3) sum = sum + byte_out.data;
      pos = byte_out.last ? 0 : pos + 1;
      if (byte_out.last) begin
        if (sum !== 8'hFF) bad_csum++;
        sum = 8'h00;
      end
    end
    byte_ready <= (slow && !reset) ? ~byte_ready : 1'b1;
  end
endmodule

// ### sim/api_status_frame_generator_tb.sv
`timescale 1ns/1ps
module api_status_frame_generator_tb;
  import status_frame_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic tx_done_valid = 1'b0;
  logic modem_event_valid = 1'b0;
  logic watchdog_reset_cause = 1'b0;
  logic slow = 1'b0;
  tx_done_s tx_done = '0;
  logic [7:0] modem_event_code = 8'h00;
  logic tx_done_ready, modem_event_ready, byte_valid, byte_ready, tx_suppressed, sup;
  out_byte_s byte_out;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  api_status_frame_generator u_api_status_frame_generator (
    .sys_clk(sys_clk),
    .reset(reset),
    .tx_done_valid(tx_done_valid),
    .tx_done(tx_done),
    .tx_done_ready(tx_done_ready),
    .modem_event_valid(modem_event_valid),
    .modem_event_code(modem_event_code),
    .watchdog_reset_cause(watchdog_reset_cause),
    .modem_event_ready(modem_event_ready),
    .byte_valid(byte_valid),
    .byte_out(byte_out),
    .byte_ready(byte_ready),
    .tx_suppressed(tx_suppressed)
  );
  host_sink u_host_sink (
    .sys_clk(sys_clk),
    .reset(reset),
    .byte_valid(byte_valid),
    .byte_out(byte_out),
    .slow(slow),
    .byte_ready(byte_ready)
  );

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_byte(input out_byte_s got, input out_byte_s exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic offer(input bit tx, input logic [7:0] a, b, input logic bc);
    int i;
    if (tx) begin
      tx_done <= '{TYPE_TX_REQ64, a, bc, b};
      tx_done_valid <= 1'b1;
    end else begin
      modem_event_code <= a;
      modem_event_valid <= 1'b1;
    end
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while ((tx ? tx_done_ready : modem_event_ready) !== 1'b1 && i < 100);
    sup = tx_suppressed;
    chk_flag(tx ? tx_done_ready : modem_event_ready, 1'b1);
    tx_done_valid <= 1'b0;
    modem_event_valid <= 1'b0;
  endtask

  task automatic await_frame(input int base, input logic [7:0] typ, f4, f5, input bit tx);
    logic [7:0] e[$];
    int i;
    e = {START_DELIM, 8'h00, tx ? 8'h03 : 8'h02, typ, f4};
    if (tx) e.push_back(f5);
    e.push_back(8'hFF - typ - f4 - (tx ? f5 : 8'h00));
    i = 0;
    while (u_host_sink.q.size() < base + e.size() && i < 300) begin
      @(posedge sys_clk);
      i++;
    end
    foreach (e[k]) chk_byte(u_host_sink.q[base + k], {e[k], k == e.size() - 1});
    chk_flag(u_host_sink.bad_csum == 0, 1'b1);
  endtask

  task automatic xfer(input bit tx, input logic [7:0] a, b, input logic bc, input logic [7:0] eb);
    int base;
    base = u_host_sink.q.size();
    offer(tx, a, b, bc);
    chk_flag(sup, 1'b0);
    await_frame(base, tx ? TYPE_TX_STATUS : TYPE_MODEM_STATUS, a, eb, tx);
  endtask

  task automatic t_boot(input logic wd);
    int base;
    watchdog_reset_cause <= wd;
    reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    base = u_host_sink.q.size();
    reset <= 1'b0;
    await_frame(base, TYPE_MODEM_STATUS, {7'h00, wd}, 8'h00, 1'b0);
    watchdog_reset_cause <= 1'b0;
  endtask

  task automatic t_tx();
    xfer(1'b1, 8'h52, 8'h00, 1'b0, 8'h00);
    xfer(1'b1, 8'h5A, 8'h21, 1'b1, 8'h00);
  endtask

  task automatic t_codes();
    logic [7:0] ds[13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h20, 8'h21, 8'h25, 8'h31, 8'h32, 8'h34, 8'h35,
      8'h74, 8'h75};
    slow <= 1'b1;
    foreach (ds[k]) xfer(1'b1, 8'hA0 + 8'(k), ds[k], 1'b0, ds[k]);
    slow <= 1'b0;
  endtask

  task automatic t_zero();
    int base;
    base = u_host_sink.q.size();
    offer(1'b1, 8'h00, 8'h02, 1'b0);
    chk_flag(sup, 1'b1);
    repeat (20) @(posedge sys_clk);
    chk_flag(u_host_sink.q.size() == base, 1'b1);
  endtask

  task automatic t_modem();
    logic [7:0] ms[9] = '{8'h00, 8'h01, 8'h0B, 8'h0C, 8'h0D, 8'h33, 8'h3B, 8'h3C, 8'h3D};
    foreach (ms[k]) xfer(1'b0, ms[k], 8'h00, 1'b0, 8'h00);
  endtask

  initial begin
    t_boot(1'b0);
    t_tx();
    t_codes();
    t_zero();
    t_modem();
    t_boot(1'b1);
    final_report();
  end
endmodule
